// [inc/core_regs_pkg.sv]
// constants and carrier types for the core register block
package core_regs_pkg;
  localparam int unsigned  pc_width           = 15;
  localparam int unsigned  addr_width         = 12;
  localparam int unsigned  sp_width           = 5;
  localparam int unsigned  latch_width        = 7;
  localparam int unsigned  bank_sel_width     = 5;
  localparam int unsigned  flags_width        = 3;
  localparam int unsigned  stack_depth        = 16;
  localparam logic [11:0]  flags_shadow_addr  = 12'hfe4;
  localparam logic [11:0]  acc_shadow_addr    = 12'hfe5;
  localparam logic [11:0]  bsr_shadow_addr    = 12'hfe6;
  localparam logic [11:0]  latch_shadow_addr  = 12'hfe7;
  localparam logic [11:0]  ptr0_low_addr      = 12'hfe8;
  localparam logic [11:0]  ptr0_high_addr     = 12'hfe9;
  localparam logic [11:0]  ptr1_low_addr      = 12'hfea;
  localparam logic [11:0]  ptr1_high_addr     = 12'hfeb;
  localparam logic [11:0]  gap_addr           = 12'hfec;
  localparam logic [11:0]  stack_ptr_addr     = 12'hfed;
  localparam logic [11:0]  top_low_addr       = 12'hfee;
  localparam logic [11:0]  top_high_addr      = 12'hfef;
  localparam logic [11:0]  pc_low_addr        = 12'h002;
  localparam logic [11:0]  pc_latch_addr      = 12'h00a;
  localparam logic [11:0]  bank31_base        = 12'hf80;
  localparam logic [14:0]  pc_reset           = 15'h0000;
  localparam logic [4:0]   sp_empty           = 5'h1f;
  localparam logic [7:0]   byte_zero          = 8'h00;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } reg_access_type;

  typedef struct packed {
    logic        fetch;
    logic        jump;
    logic [14:0] target;
  } pc_control_type;
endpackage

// [rtl/pc_stack_shadow_regs.sv]
// program counter, stack access and shadow register bank
`timescale 1ns/1ps
`default_nettype none
module pc_stack_shadow_regs
  import core_regs_pkg::*;
#(
  parameter int unsigned depth = core_regs_pkg::stack_depth
)
(
  // clock and reset
  input  wire logic                         sys_clk,
  input  wire logic                         reset,
  // register access from the core
  input  wire core_regs_pkg::reg_access_type access,
  input  wire logic                         debug_mode,
  output logic [7:0]                        rdata,
  // program counter control
  input  wire core_regs_pkg::pc_control_type pc_ctl,
  output logic [14:0]                       pc,
  output logic [4:0]                        stack_pointer,
  // live context captured into the shadows on debug entry
  input  wire logic                         shadow_capture,
  input  wire logic [7:0]                   live_acc,
  input  wire logic [4:0]                   live_bsr,
  input  wire logic [2:0]                   live_flags,
  input  wire logic [15:0]                  live_ptr0,
  input  wire logic [15:0]                  live_ptr1
);
  import core_regs_pkg::*;

  logic [14:0] pc_q;
  logic [14:0] pc_d;
  logic [6:0]  latch_q;
  logic [6:0]  latch_d;
  logic [4:0]  sp_q;
  logic [4:0]  sp_d;
  logic [2:0]  flags_sh_q;
  logic [7:0]  acc_sh_q;
  logic [4:0]  bsr_sh_q;
  logic [6:0]  latch_sh_q;
  logic [7:0]  ptr0l_sh_q;
  logic [7:0]  ptr0h_sh_q;
  logic [7:0]  ptr1l_sh_q;
  logic [7:0]  ptr1h_sh_q;
  logic [14:0] stack_q [depth];
  logic [3:0]  sp_idx;
  logic [7:0]  rdata_d;
  logic [7:0]  rdata_q;
  logic        in_bank31;
  logic        allowed;
  logic        wr_ok;
  logic        rd_ok;
  logic        wr_pcl;
  logic        wr_latch;
  logic        wr_sp;
  logic        wr_top_low;
  logic        wr_top_high;
  logic        wr_flags_sh;
  logic        wr_acc_sh;
  logic        wr_bsr_sh;
  logic        wr_latch_sh;
  logic        wr_ptr0l_sh;
  logic        wr_ptr0h_sh;
  logic        wr_ptr1l_sh;
  logic        wr_ptr1h_sh;

  assign sp_idx = sp_q[3:0];
  assign in_bank31 = (access.addr >= bank31_base);
  // shadow and stack registers are open to user code as well
  assign allowed = !in_bank31 || debug_mode ||
                   (access.addr >= flags_shadow_addr &&
                    access.addr <= top_high_addr);
  assign wr_ok = access.wr && allowed;
  assign rd_ok = access.rd && allowed;

  // one write strobe per register; blocked addresses never strobe
  always_comb
  begin
    wr_pcl      = 1'h0;
    wr_latch    = 1'h0;
    wr_sp       = 1'h0;
    wr_top_low  = 1'h0;
    wr_top_high = 1'h0;
    wr_flags_sh = 1'h0;
    wr_acc_sh   = 1'h0;
    wr_bsr_sh   = 1'h0;
    wr_latch_sh = 1'h0;
    wr_ptr0l_sh = 1'h0;
    wr_ptr0h_sh = 1'h0;
    wr_ptr1l_sh = 1'h0;
    wr_ptr1h_sh = 1'h0;
    if (wr_ok)
    begin
      case (access.addr)
        pc_low_addr:       wr_pcl      = 1'h1;
        pc_latch_addr:     wr_latch    = 1'h1;
        stack_ptr_addr:    wr_sp       = 1'h1;
        top_low_addr:      wr_top_low  = 1'h1;
        top_high_addr:     wr_top_high = 1'h1;
        flags_shadow_addr: wr_flags_sh = 1'h1;
        acc_shadow_addr:   wr_acc_sh   = 1'h1;
        bsr_shadow_addr:   wr_bsr_sh   = 1'h1;
        latch_shadow_addr: wr_latch_sh = 1'h1;
        ptr0_low_addr:     wr_ptr0l_sh = 1'h1;
        ptr0_high_addr:    wr_ptr0h_sh = 1'h1;
        ptr1_low_addr:     wr_ptr1l_sh = 1'h1;
        ptr1_high_addr:    wr_ptr1h_sh = 1'h1;
        default:           wr_pcl      = 1'h0;
      endcase
    end
  end

  // next pc: a low-byte write beats a jump, a jump beats a fetch
  always_comb
  begin
    pc_d = pc_q;
    if (wr_pcl)
      pc_d = {latch_q, access.wdata};
    else if (pc_ctl.jump)
      pc_d = pc_ctl.target;
    else if (pc_ctl.fetch)
      pc_d = pc_q + 15'h0001;
  end

  // program counter
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      pc_q <= pc_reset;
    else
      pc_q <= pc_d;
  end

  // pc high latch
  always_comb
  begin
    latch_d = latch_q;
    if (wr_latch)
      latch_d = access.wdata[6:0];
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      latch_q <= 7'h00;
    else
      latch_q <= latch_d;
  end

  // stack pointer, written by software only
  always_comb
  begin
    sp_d = sp_q;
    if (wr_sp)
      sp_d = access.wdata[4:0];
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      sp_q <= sp_empty;
    else
      sp_q <= sp_d;
  end

  // top of stack entry selected by the pointer
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      for (int i = 0; i < depth; i++)
        stack_q[i] <= pc_reset;
    end
    else if (wr_top_low)
      stack_q[sp_idx][7:0] <= access.wdata;
    else if (wr_top_high)
      stack_q[sp_idx][14:8] <= access.wdata[6:0];
  end

  // flags shadow; a capture beats a same-cycle write
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      flags_sh_q <= 3'h0;
    else if (shadow_capture)
      flags_sh_q <= live_flags;
    else if (wr_flags_sh)
      flags_sh_q <= access.wdata[2:0];
  end

  // working register shadow
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      acc_sh_q <= 8'h00;
    else if (shadow_capture)
      acc_sh_q <= live_acc;
    else if (wr_acc_sh)
      acc_sh_q <= access.wdata;
  end

  // bank select shadow
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      bsr_sh_q <= 5'h00;
    else if (shadow_capture)
      bsr_sh_q <= live_bsr;
    else if (wr_bsr_sh)
      bsr_sh_q <= access.wdata[4:0];
  end

  // pc high latch shadow
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      latch_sh_q <= 7'h00;
    else if (shadow_capture)
      latch_sh_q <= latch_q;
    else if (wr_latch_sh)
      latch_sh_q <= access.wdata[6:0];
  end

  // pointer 0 low byte shadow
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      ptr0l_sh_q <= 8'h00;
    else if (shadow_capture)
      ptr0l_sh_q <= live_ptr0[7:0];
    else if (wr_ptr0l_sh)
      ptr0l_sh_q <= access.wdata;
  end

  // pointer 0 high byte shadow
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      ptr0h_sh_q <= 8'h00;
    else if (shadow_capture)
      ptr0h_sh_q <= live_ptr0[15:8];
    else if (wr_ptr0h_sh)
      ptr0h_sh_q <= access.wdata;
  end

  // pointer 1 low byte shadow
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      ptr1l_sh_q <= 8'h00;
    else if (shadow_capture)
      ptr1l_sh_q <= live_ptr1[7:0];
    else if (wr_ptr1l_sh)
      ptr1l_sh_q <= access.wdata;
  end

  // pointer 1 high byte shadow
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      ptr1h_sh_q <= 8'h00;
    else if (shadow_capture)
      ptr1h_sh_q <= live_ptr1[15:8];
    else if (wr_ptr1h_sh)
      ptr1h_sh_q <= access.wdata;
  end

  // read mux; unmapped, blocked and idle reads give zero
  always_comb
  begin
    rdata_d = byte_zero;
    if (rd_ok)
    begin
      case (access.addr)
        pc_low_addr:       rdata_d = pc_q[7:0];
        pc_latch_addr:     rdata_d = {1'h0, latch_q};
        flags_shadow_addr: rdata_d = {5'h00, flags_sh_q};
        acc_shadow_addr:   rdata_d = acc_sh_q;
        bsr_shadow_addr:   rdata_d = {3'h0, bsr_sh_q};
        latch_shadow_addr: rdata_d = {1'h0, latch_sh_q};
        ptr0_low_addr:     rdata_d = ptr0l_sh_q;
        ptr0_high_addr:    rdata_d = ptr0h_sh_q;
        ptr1_low_addr:     rdata_d = ptr1l_sh_q;
        ptr1_high_addr:    rdata_d = ptr1h_sh_q;
        stack_ptr_addr:    rdata_d = {3'h0, sp_q};
        top_low_addr:      rdata_d = stack_q[sp_idx][7:0];
        top_high_addr:     rdata_d = {1'h0, stack_q[sp_idx][14:8]};
        default:           rdata_d = byte_zero;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      rdata_q <= byte_zero;
    else
      rdata_q <= rdata_d;
  end

  assign rdata = rdata_q;
  assign pc = pc_q;
  assign stack_pointer = sp_q;
endmodule
`default_nettype wire

// [tb/pc_stack_shadow_regs_monitor.sv]
// assertion checker for the pc, stack and shadow register block
`timescale 1ns/1ps
`default_nettype none
module pc_stack_shadow_regs_monitor
  import core_regs_pkg::*;
(
  // watched ports
  input wire logic                           sys_clk,
  input wire logic                           reset,
  input wire core_regs_pkg::reg_access_type  access,
  input wire logic                           debug_mode,
  input wire logic [7:0]                     rdata,
  input wire core_regs_pkg::pc_control_type  pc_ctl,
  input wire logic [14:0]                    pc,
  input wire logic [4:0]                     stack_pointer
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic pcw;
  assign pcw = access.wr && access.addr == pc_low_addr;
  sequence s_latch_then_low;
    access.wr && access.addr == pc_latch_addr ##1 pcw;
  endsequence
  a_reset_clears_pc: assert property ($past(reset) |->
    pc == 15'h0000 && stack_pointer == 5'h1f) else $error("reset values");
  a_fetch_step: assert property (pc_ctl.fetch && !pc_ctl.jump && !pcw
    |=> pc == $past(pc) + 15'h0001) else $error("fetch step");
  a_jump_load: assert property (pc_ctl.jump && !pcw
    |=> pc == $past(pc_ctl.target)) else $error("jump load");
  a_full_pc_load: assert property (s_latch_then_low |=> pc ==
    {$past(access.wdata[6:0], 2), $past(access.wdata)}) else $error("load");
  a_pc_high_holds: assert property (!pc_ctl.fetch && !pc_ctl.jump
    && !pcw |=> $stable(pc)) else $error("pc moved");
  a_gap_reads_zero: assert property (access.rd && access.addr == gap_addr
    |=> rdata == 8'h00) else $error("gap read");
  a_user_fence: assert property (access.rd && !debug_mode
    && access.addr >= bank31_base && access.addr < flags_shadow_addr
    |=> rdata == 8'h00) else $error("fenced read");
  a_sp_read: assert property (access.rd && access.addr == stack_ptr_addr
    |=> rdata == {3'h0, $past(stack_pointer)}) else $error("sp read");
endmodule
bind pc_stack_shadow_regs pc_stack_shadow_regs_monitor mon_u (
  .sys_clk(sys_clk), .reset(reset), .access(access),
  .debug_mode(debug_mode), .rdata(rdata), .pc_ctl(pc_ctl), .pc(pc),
  .stack_pointer(stack_pointer));
`default_nettype wire

// [tb/pc_stack_shadow_regs_tb.sv]
// self-checking testbench for the pc, stack and shadow register block
`timescale 1ns/1ps
`default_nettype none
module pc_stack_shadow_regs_tb;
  import core_regs_pkg::*;
  logic           sys_clk = 1'b0;
  logic           reset = 1'b1;
  reg_access_type access = '0;
  logic           debug_mode = 1'b0;
  logic [7:0]     rdata;
  pc_control_type pc_ctl = '0;
  logic [14:0]    pc;
  logic [4:0]     stack_pointer;
  logic           shadow_capture = 1'b0;
  int             err_count = 0;
  int             compares = 0;
  int             cycles = 0;
  logic [7:0]     m [12] = '{8'h07, 8'hff, 8'h1f, 8'h7f, 8'hff, 8'hff,
                             8'hff, 8'hff, 8'h00, 8'h1f, 8'hff, 8'h7f};
  pc_stack_shadow_regs dut_u (.sys_clk(sys_clk), .reset(reset),
    .access(access), .debug_mode(debug_mode), .rdata(rdata),
    .pc_ctl(pc_ctl), .pc(pc), .stack_pointer(stack_pointer),
    .shadow_capture(shadow_capture), .live_acc(8'ha5), .live_bsr(5'h15),
    .live_flags(3'h6), .live_ptr0(16'h1234), .live_ptr1(16'hbeef));
  initial forever #50 sys_clk = ~sys_clk;
  task automatic conclude();
    $display("mismatches %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      err_count++;
      conclude();
    end
  end
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic op(logic r, logic w, logic [11:0] a, logic [7:0] d);
    access = {r, w, a, d};
    @(negedge sys_clk);
  endtask
  task automatic rd_chk(logic [11:0] a, logic [7:0] e);
    op(1'b1, 1'b0, a, 8'h00);
    check("rdata", {8'h00, rdata}, {8'h00, e});
  endtask
  task automatic t_pc();
    op(1'b0, 1'b1, pc_latch_addr, 8'hff);
    op(1'b0, 1'b1, pc_low_addr, 8'h34);
    check("pc", {1'b0, pc}, 16'h7f34);
    rd_chk(pc_low_addr, 8'h34);
    check("pc", {1'b0, pc}, 16'h7f34);
    pc_ctl = {1'b1, 1'b0, 15'h0000};
    op(1'b0, 1'b0, 12'h000, 8'h00);
    op(1'b0, 1'b0, 12'h000, 8'h00);
    check("pc", {1'b0, pc}, 16'h7f36);
    pc_ctl = {1'b1, 1'b1, 15'h7fff};
    op(1'b0, 1'b0, 12'h000, 8'h00);
    pc_ctl = {1'b1, 1'b0, 15'h0000};
    op(1'b0, 1'b0, 12'h000, 8'h00);
    pc_ctl = '0;
    check("pc", {1'b0, pc}, 16'h0000);
    pc_ctl = {1'b1, 1'b0, 15'h0000};
    reset = 1'b1;
    op(1'b0, 1'b0, 12'h000, 8'h00);
    reset = 1'b0;
    pc_ctl = '0;
    check("pc", {1'b0, pc}, 16'h0000);
  endtask
  task automatic t_regs();
    rd_chk(12'hf90, 8'h00);
    for (int i = 0; i < 12; i++)
    begin
      op(1'b0, 1'b1, 12'hfe4 + 12'(i), 8'hff);
      rd_chk(12'hfe4 + 12'(i), m[i]);
    end
    op(1'b0, 1'b1, stack_ptr_addr, 8'h03);
    op(1'b0, 1'b1, top_low_addr, 8'hab);
    rd_chk(top_low_addr, 8'hab);
    op(1'b0, 1'b1, stack_ptr_addr, 8'h04);
    rd_chk(top_low_addr, 8'h00);
    check("sp", {11'h000, stack_pointer}, 16'h0004);
  endtask
  task automatic t_capture();
    debug_mode = 1'b1;
    op(1'b0, 1'b1, pc_latch_addr, 8'h55);
    shadow_capture = 1'b1;
    op(1'b0, 1'b0, 12'h000, 8'h00);
    shadow_capture = 1'b0;
    rd_chk(flags_shadow_addr, 8'h06);
    rd_chk(acc_shadow_addr, 8'ha5);
    rd_chk(bsr_shadow_addr, 8'h15);
    rd_chk(latch_shadow_addr, 8'h55);
    rd_chk(ptr0_high_addr, 8'h12);
    rd_chk(ptr1_low_addr, 8'hef);
    rd_chk(ptr0_low_addr, 8'h34);
    rd_chk(ptr1_high_addr, 8'hbe);
    rd_chk(12'hfe3, 8'h00);
  endtask
  initial
  begin
    repeat (12) @(negedge sys_clk);
    reset = 1'b0;
    check("pc", {1'b0, pc}, 16'h0000);
    rd_chk(stack_ptr_addr, 8'h1f);
    rd_chk(gap_addr, 8'h00);
    t_pc();
    t_regs();
    t_capture();
    conclude();
  end
endmodule
`default_nettype wire
